// ### sarseq_pkg.sv
package sarseq_pkg;

  // Control word layout and select-field position.
  localparam int CTRL_W = 16;
  localparam int SEL_HI = 14;
  localparam int SEL_LO = 11;
  localparam int SEL_W = 4;
  localparam int GAIN_BIT = 15;
  localparam int RES_W = 10;
  localparam int NUM_IN = 8;

  // Channel-select codes.
  localparam logic [3:0] SEL_SE_LAST = 4'h7;
  localparam logic [3:0] SEL_DIFF01 = 4'hA;
  localparam logic [3:0] SEL_DIFF67 = 4'hD;
  localparam logic [3:0] SEL_TRIM = 4'hF;

  // Mux route kinds.
  localparam logic [1:0] ROUTE_SE = 2'h0;
  localparam logic [1:0] ROUTE_DIFF = 2'h1;
  localparam logic [1:0] ROUTE_TRIM = 2'h2;
  localparam logic [1:0] ROUTE_NONE = 2'h3;

  // Stage lengths in converter clock half-periods (26.5 periods needs halves).
  localparam int HALF_PER_CLK = 2;
  localparam int TRACK_HALVES = 6 * HALF_PER_CLK;
  localparam int AMP_HALVES = 21;
  localparam int UNITY_TOTAL_HALVES = 32;
  localparam int GAIN_TOTAL_HALVES = 53;
  localparam int CNT_W = 6;

  // Converter clock period and unity-gain conversion time at the nominal 4 MHz converter clock, in ns.
  localparam int CONV_CLK_NS = 250;
  localparam int UNITY_CONV_NS = 4000;

  typedef enum logic [4:0] {
    SARSEQ_IDLE = 5'h01,
    SARSEQ_AMP = 5'h02,
    SARSEQ_TRACK = 5'h04,
    SARSEQ_SAR = 5'h08,
    SARSEQ_DONE = 5'h10
  } sarseq_state_e;

endpackage : sarseq_pkg

// ### sarseq_sar_reg.sv
`timescale 1ns/1ps
// Successive-approximation register: one bit decision per step, the same for both gains.
module sarseq_sar_reg #(
  parameter int RES_W = 10
) (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable.
  input wire logic load, // Starts a new approximation.
  input wire logic step, // Takes one comparator decision.
  input wire logic cmp_hi, // Comparator: input above trial value.
  output logic [RES_W-1:0] trial_q, // Trial code to the DAC.
  output logic [RES_W-1:0] result_q, // Finished code.
  output logic last_q // Pulses when the last bit is decided.
);

  logic [RES_W-1:0] mask_q;

  // Walk the trial bit from MSB to LSB, keeping or dropping each one.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      trial_q <= '0;
      mask_q <= '0;
      result_q <= '0;
      last_q <= 1'b0;
    end else if (ce) begin
      last_q <= 1'b0;
      if (load) begin
        mask_q <= {1'b1, {(RES_W-1){1'b0}}};
        trial_q <= {1'b1, {(RES_W-1){1'b0}}};
      end else if (step && (mask_q != '0)) begin
        mask_q <= mask_q >> 1;
        trial_q <= (cmp_hi ? trial_q : (trial_q & ~mask_q)) | (mask_q >> 1);
        if (mask_q[0]) begin
          result_q <= cmp_hi ? trial_q : (trial_q & ~mask_q);
          last_q <= 1'b1;
        end
      end
    end
  end

endmodule : sarseq_sar_reg

// ### sarseq_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Select codes 0000 to 0111 in bits 14:11 route input n to signal and analog ground to reference.
// - Codes 1010 to 1101 route pairs 0/1, 2/3, 4/5, 6/7 with the even input as signal.
// - Code 1111 selects the zero-offset trim setting; codes 1000, 1001, 1110 are reserved.
// - Unity gain bypasses the amplifier and gain 16 enables it, each with its own sequence.
// - A unity-gain conversion is a track then hold cycle of exactly 16 converter clock periods.
// - At unity gain the positive capacitor tracks signal, the negative tracks reference, then 10 bits convert.
// - At gain 16 the amplifier stage, converter track and hold/convert stages take 26.5 periods in all.
// - The bit decisions run one per period at both gains, but start half a period sooner in hold at gain 16.
// - Throughput reaches 250 ksps at unity gain and 150.9 ksps at gain 16.
// - With a 4 MHz converter clock a unity-gain conversion lasts 4 microseconds.
module sarseq_top #(
  parameter int RES_W = sarseq_pkg::RES_W,
  parameter int NUM_IN = sarseq_pkg::NUM_IN
) (
  input wire logic clk_sys, // System clock, 50 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable, freezes all state when low.
  input wire logic conv_half_tick, // One-cycle pulse per converter clock half-period.
  input wire logic start, // Software start request, one cycle.
  input wire logic [sarseq_pkg::CTRL_W-1:0] converter_control_word, // Control word.
  input wire logic done_clear, // Software clear of the done flag.
  input wire logic cmp_hi, // Comparator result from the converter.
  output logic [NUM_IN-1:0] sig_sel_q, // One-hot signal-side input select.
  output logic [NUM_IN-1:0] ref_sel_q, // One-hot reference-side input select.
  output logic ref_gnd_q, // Reference side tied to analog ground.
  output logic trim_sel_q, // Both sides on the trim level.
  output logic amp_en_q, // Gain amplifier enabled.
  output logic amp_track_q, // Amplifier tracking.
  output logic cap_track_q, // Sampling capacitors tracking.
  output logic sar_active_q, // Bit decisions running.
  output logic [RES_W-1:0] dac_code_q, // Trial code to the converter DAC.
  output logic [RES_W-1:0] result_q, // Last 10-bit result.
  output logic busy_q, // Conversion in progress.
  output logic done_q, // Result available flag.
  output logic sel_reserved_q // Latched select code was reserved.
);

  sarseq_pkg::sarseq_state_e state_q;
  logic [sarseq_pkg::SEL_W-1:0] sel_q;
  logic gain_q;
  logic [sarseq_pkg::CNT_W-1:0] cnt_q;
  logic [sarseq_pkg::CNT_W-1:0] total_q;
  logic [1:0] route;
  logic [RES_W-1:0] trial;
  logic [RES_W-1:0] sar_result;
  logic sar_last;
  logic sar_load;
  logic sar_step;

  // Decode a select code into a route kind; reserved codes route nothing.
  function automatic logic [1:0] route_of(input logic [3:0] s);
    if (s <= sarseq_pkg::SEL_SE_LAST) begin
      route_of = sarseq_pkg::ROUTE_SE;
    end else if (s >= sarseq_pkg::SEL_DIFF01 && s <= sarseq_pkg::SEL_DIFF67) begin
      route_of = sarseq_pkg::ROUTE_DIFF;
    end else if (s == sarseq_pkg::SEL_TRIM) begin
      route_of = sarseq_pkg::ROUTE_TRIM;
    end else begin
      route_of = sarseq_pkg::ROUTE_NONE;
    end
  endfunction : route_of

  assign route = route_of(sel_q);

  // Accept a start only when idle; the latched settings hold for the whole cycle.
  // latch on start
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sel_q <= '0;
      gain_q <= 1'b0;
    end else if (ce && start && state_q == sarseq_pkg::SARSEQ_IDLE) begin
      sel_q <= converter_control_word[sarseq_pkg::SEL_HI:sarseq_pkg::SEL_LO];
      gain_q <= converter_control_word[sarseq_pkg::GAIN_BIT];
    end
  end

  // Sequencer; timing is counted in half-periods so gain 16 can end on 26.5 periods.
  // gain picks sequence
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= sarseq_pkg::SARSEQ_IDLE;
      cnt_q <= '0;
      total_q <= '0;
    end else if (ce) begin
      unique case (state_q)
        sarseq_pkg::SARSEQ_IDLE: begin
          if (start) begin
            cnt_q <= '0;
            total_q <= '0;
            state_q <= converter_control_word[sarseq_pkg::GAIN_BIT] ? sarseq_pkg::SARSEQ_AMP
                                                                    : sarseq_pkg::SARSEQ_TRACK;
          end
        end
        sarseq_pkg::SARSEQ_AMP: begin
          if (conv_half_tick) begin
            total_q <= total_q + 1'b1;
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == sarseq_pkg::CNT_W'(sarseq_pkg::AMP_HALVES - 1)) begin
              cnt_q <= '0;
              state_q <= sarseq_pkg::SARSEQ_TRACK;
            end
          end
        end
        sarseq_pkg::SARSEQ_TRACK: begin
          if (conv_half_tick) begin
            total_q <= total_q + 1'b1;
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == sarseq_pkg::CNT_W'(sarseq_pkg::TRACK_HALVES - 1)) begin
              cnt_q <= '0;
              state_q <= sarseq_pkg::SARSEQ_SAR;
            end
          end
        end
        sarseq_pkg::SARSEQ_SAR: begin
          if (conv_half_tick) begin
            total_q <= total_q + 1'b1;
            if (total_q == (gain_q ? sarseq_pkg::CNT_W'(sarseq_pkg::GAIN_TOTAL_HALVES - 1)
                                   : sarseq_pkg::CNT_W'(sarseq_pkg::UNITY_TOTAL_HALVES - 1))) begin
              state_q <= sarseq_pkg::SARSEQ_DONE;
            end
          end
        end
        sarseq_pkg::SARSEQ_DONE: begin
          state_q <= sarseq_pkg::SARSEQ_IDLE;
        end
        default: begin
          state_q <= sarseq_pkg::SARSEQ_IDLE;
        end
      endcase
    end
  end

  // One decision per full converter period on odd total_q, so at gain 16 they start half a period sooner after hold begins.
  // shared bit decisions
  assign sar_load = (state_q == sarseq_pkg::SARSEQ_TRACK) && conv_half_tick
                    && (cnt_q == sarseq_pkg::CNT_W'(sarseq_pkg::TRACK_HALVES - 1));
  assign sar_step = (state_q == sarseq_pkg::SARSEQ_SAR) && conv_half_tick && total_q[0];

  sarseq_sar_reg #(
    .RES_W(RES_W)
  ) u_sar (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .load(sar_load),
    .step(sar_step),
    .cmp_hi(cmp_hi),
    .trial_q(trial),
    .result_q(sar_result),
    .last_q(sar_last)
  );

  // Multiplexer selects, generated per input; reserved codes leave every switch open.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_mux
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          sig_sel_q[gi] <= 1'b0;
          ref_sel_q[gi] <= 1'b0;
        end else if (ce) begin
          sig_sel_q[gi] <= (route == sarseq_pkg::ROUTE_SE && sel_q[2:0] == 3'(gi))
                        || (route == sarseq_pkg::ROUTE_DIFF && gi % 2 == 0
                            && 3'(sel_q - sarseq_pkg::SEL_DIFF01) == 3'(gi / 2));
          ref_sel_q[gi] <= route == sarseq_pkg::ROUTE_DIFF && gi % 2 == 1
                        && 3'(sel_q - sarseq_pkg::SEL_DIFF01) == 3'(gi / 2);
        end
      end
    end
  endgenerate

  // Route kind and stage outputs.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ref_gnd_q <= 1'b0;
      trim_sel_q <= 1'b0;
      sel_reserved_q <= 1'b0;
      amp_en_q <= 1'b0;
      amp_track_q <= 1'b0;
      cap_track_q <= 1'b0;
      sar_active_q <= 1'b0;
      busy_q <= 1'b0;
      dac_code_q <= '0;
    end else if (ce) begin
      ref_gnd_q <= route == sarseq_pkg::ROUTE_SE;
      trim_sel_q <= route == sarseq_pkg::ROUTE_TRIM;
      sel_reserved_q <= route == sarseq_pkg::ROUTE_NONE;
      // Busy and amplifier enable follow the next state, so no one sees idle while a start would be refused.
      amp_en_q <= (state_q == sarseq_pkg::SARSEQ_IDLE) ? (start && converter_control_word[sarseq_pkg::GAIN_BIT])
                                                        : (gain_q && state_q != sarseq_pkg::SARSEQ_DONE);
      amp_track_q <= state_q == sarseq_pkg::SARSEQ_AMP;
      cap_track_q <= state_q == sarseq_pkg::SARSEQ_TRACK;
      sar_active_q <= state_q == sarseq_pkg::SARSEQ_SAR;
      busy_q <= (state_q == sarseq_pkg::SARSEQ_IDLE) ? start : (state_q != sarseq_pkg::SARSEQ_DONE);
      dac_code_q <= trial;
    end
  end

  // Done flag: a new completion wins over a clear in the same cycle.
  // completion flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result_q <= '0;
      done_q <= 1'b0;
    end else if (ce) begin
      if (sar_last) begin
        result_q <= sar_result;
      end
      if (state_q == sarseq_pkg::SARSEQ_DONE) begin
        done_q <= 1'b1;
      end else if (done_clear) begin
        done_q <= 1'b0;
      end
    end
  end

endmodule : sarseq_top

// ### sarseq_props.sv
`timescale 1ns/1ps
// Pin-level checker; it counts converter half-ticks so that each conversion is measured on its own.
module sarseq_props #(
  parameter int RES_W = 10,
  parameter int NUM_IN = 8
) (
  input wire logic clk_sys, // Clock.
  input wire logic rst, // Reset.
  input wire logic ce, // Enable.
  input wire logic conv_half_tick, // Half-tick.
  input wire logic start, // Start.
  input wire logic [15:0] converter_control_word, // Control.
  input wire logic done_clear, // Clear.
  input wire logic [NUM_IN-1:0] sig_sel_q, // Signal.
  input wire logic [NUM_IN-1:0] ref_sel_q, // Reference.
  input wire logic ref_gnd_q, // Ground.
  input wire logic trim_sel_q, // Trim.
  input wire logic amp_en_q, // Amp on.
  input wire logic amp_track_q, // Amp track.
  input wire logic cap_track_q, // Cap track.
  input wire logic sar_active_q, // Deciding.
  input wire logic busy_q, // Busy.
  input wire logic done_q, // Done.
  input wire logic sel_reserved_q // Reserved.
);
  logic gain_q;
  logic [6:0] tick_cnt_q;
  logic taken;
  // A start only counts when the sequencer is idle and enabled.
  assign taken = start && ce && !busy_q;
  // The gain is latched at the accepted start, as the duration checks need the sequence that ran.
  always_ff @(posedge clk_sys) begin
    if (rst) gain_q <= 1'b0;
    else if (taken) gain_q <= converter_control_word[sarseq_pkg::GAIN_BIT];
  end
  // Half-ticks since the accepted start; it saturates so a stuck run cannot wrap around.
  always_ff @(posedge clk_sys) begin
    if (rst || taken) tick_cnt_q <= 7'h00;
    else if (ce && conv_half_tick && tick_cnt_q != 7'h7F) tick_cnt_q <= tick_cnt_q + 7'h01;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_start_sets_busy: assert property (taken |-> ##[1:2] busy_q)
    else $error("accepted start did not raise busy");
  a_unity_length: assert property ($rose(done_q) && !gain_q |-> tick_cnt_q >= 7'h1F && tick_cnt_q <= 7'h21)
    else $error("unity conversion length wrong");
  a_gain_length: assert property ($rose(done_q) && gain_q |-> tick_cnt_q >= 7'h34 && tick_cnt_q <= 7'h36)
    else $error("gain conversion length wrong");
  a_amp_gain_only: assert property ((amp_en_q || amp_track_q) |-> gain_q && busy_q)
    else $error("amplifier used outside a gain conversion");
  a_track_hold_order: assert property (sar_active_q |-> !cap_track_q && !amp_track_q)
    else $error("tracking overlaps bit decisions");
  a_reserved_none: assert property (sel_reserved_q |-> sig_sel_q == '0 && ref_sel_q == '0 && !trim_sel_q)
    else $error("reserved code routed an input");
  a_single_ground: assert property (cap_track_q && ref_gnd_q |-> $onehot(sig_sel_q) && ref_sel_q == '0)
    else $error("single-ended route wrong");
  a_diff_pair: assert property (cap_track_q && ref_sel_q != '0
    |-> ref_sel_q == (sig_sel_q << 1) && !ref_gnd_q)
    else $error("differential pair wrong");
  a_clear_done: assert property (ce && done_clear && !busy_q |=> !done_q)
    else $error("done not cleared");
  a_ce_freeze: assert property (!ce |=> $stable(busy_q) && $stable(sar_active_q))
    else $error("state moved while disabled");
  a_reset_idle: assert property (disable iff (1'b0) rst && ce |=> !busy_q && !done_q && !sar_active_q)
    else $error("reset left the sequencer active");
  c_unity_done: cover property ($rose(done_q) && !gain_q);
  c_gain_done: cover property ($rose(done_q) && gain_q);
  c_reserved: cover property (sel_reserved_q && busy_q);
endmodule : sarseq_props

bind sarseq_top sarseq_props #(.RES_W(RES_W), .NUM_IN(NUM_IN)) sarseq_props_i (
  .clk_sys(clk_sys),
  .rst(rst),
  .ce(ce),
  .conv_half_tick(conv_half_tick),
  .start(start),
  .converter_control_word(converter_control_word),
  .done_clear(done_clear),
  .sig_sel_q(sig_sel_q),
  .ref_sel_q(ref_sel_q),
  .ref_gnd_q(ref_gnd_q),
  .trim_sel_q(trim_sel_q),
  .amp_en_q(amp_en_q),
  .amp_track_q(amp_track_q),
  .cap_track_q(cap_track_q),
  .sar_active_q(sar_active_q),
  .busy_q(busy_q),
  .done_q(done_q),
  .sel_reserved_q(sel_reserved_q)
);

// ### sarseq_far_model.sv
`timescale 1ns/1ps
// Far side: mux levels, gain stage, comparator and the converter half-tick source.
module sarseq_far_model #(
  parameter int HALF_DIV = 6,
  parameter logic [9:0] TRIM_LVL = 10'h023
) (
  input wire logic clk_sys, // Clock.
  input wire logic [9:0] dac_code_q, // Trial code.
  input wire logic [7:0] sig_sel_q, // Signal select.
  input wire logic [7:0] ref_sel_q, // Reference select.
  input wire logic trim_sel_q, // Trim route.
  input wire logic amp_en_q, // Gain stage on.
  output logic conv_half_tick, // Half-period tick.
  output logic cmp_hi // Comparator.
);
  int div = 0;
  logic [13:0] sig, refl, held;
  initial conv_half_tick = 1'b0;
  // Dividing by 6 gives a little over 8 MHz; the count of half-ticks, not their rate, is checked.
  always @(posedge clk_sys) begin
    div <= (div == HALF_DIV - 1) ? 0 : div + 1;
    conv_half_tick <= (div == HALF_DIV - 1);
  end
  // Levels fall with the input number so an even-minus-odd pair stays positive.
  always_comb begin
    sig = 14'h0;
    refl = 14'h0;
    for (int i = 0; i < 8; i++) begin
      if (sig_sel_q[i]) sig = 14'(10'h3F0 - 10'(i * 'h71));
      if (ref_sel_q[i]) refl = 14'(10'h3F0 - 10'(i * 'h71));
    end
    held = trim_sel_q ? 14'(TRIM_LVL) : (sig > refl ? sig - refl : 14'h0);
    if (amp_en_q) held = held << 4;
    cmp_hi = ((held > 14'h3FF) ? 14'h3FF : held) >= 14'(dac_code_q);
  end
endmodule : sarseq_far_model

// ### sarseq_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module sarseq_top_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic start = 1'b0;
  logic done_clear = 1'b0;
  logic [15:0] converter_control_word = 16'h0000;
  logic conv_half_tick, cmp_hi, ref_gnd_q, trim_sel_q, amp_en_q, amp_track_q;
  logic cap_track_q, sar_active_q, busy_q, done_q, sel_reserved_q;
  logic [7:0] sig_sel_q, ref_sel_q;
  logic [9:0] dac_code_q, result_q;
  int n_fail = 0;
  int check_count = 0;
  int ticks = 0;
  always #10 clk_sys = ~clk_sys;
  sarseq_top sarseq_top_i (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .conv_half_tick(conv_half_tick),
    .start(start),
    .converter_control_word(converter_control_word),
    .done_clear(done_clear),
    .cmp_hi(cmp_hi),
    .sig_sel_q(sig_sel_q),
    .ref_sel_q(ref_sel_q),
    .ref_gnd_q(ref_gnd_q),
    .trim_sel_q(trim_sel_q),
    .amp_en_q(amp_en_q),
    .amp_track_q(amp_track_q),
    .cap_track_q(cap_track_q),
    .sar_active_q(sar_active_q),
    .dac_code_q(dac_code_q),
    .result_q(result_q),
    .busy_q(busy_q),
    .done_q(done_q),
    .sel_reserved_q(sel_reserved_q)
  );
  sarseq_far_model sarseq_far_model_i (
    .clk_sys(clk_sys),
    .dac_code_q(dac_code_q),
    .sig_sel_q(sig_sel_q),
    .ref_sel_q(ref_sel_q),
    .trim_sel_q(trim_sel_q),
    .amp_en_q(amp_en_q),
    .conv_half_tick(conv_half_tick),
    .cmp_hi(cmp_hi)
  );
  // Half-ticks are counted only while enabled, since a frozen sequencer ignores them.
  always @(posedge clk_sys) if (ce && conv_half_tick) ticks++;
  function automatic logic [9:0] exp_res(input logic [3:0] c, input logic g);
    logic [13:0] d;
    d = 14'h0;
    if (c <= 4'h7) d = 14'(10'h3F0 - 10'(c * 'h71));
    else if (c >= 4'hA && c <= 4'hD) d = 14'h071;
    else if (c == 4'hF) d = 14'h023;
    if (g) d = d << 4;
    return (d > 14'h3FF) ? 10'h3FF : d[9:0];
  endfunction : exp_res
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  // One conversion; poke adds a refused start and a clock-enable pause in mid-run.
  task automatic run_conv(input logic [3:0] c, input logic g, input logic poke);
    int w;
    logic dif;
    int ns;
    dif = c >= 4'hA && c <= 4'hD;
    done_clear = 1'b1;
    step(1);
    done_clear = 1'b0;
    `CHK(done_q, 1'b0)
    converter_control_word = {g, c, 11'h5A5};
    start = 1'b1;
    ticks = 0;
    step(1);
    start = 1'b0;
    step(1);
    `CHK(amp_track_q, g)
    for (w = 0; w < 400 && cap_track_q !== 1'b1; w++) step(1);
    `CHK(ticks >= (g ? 21 : 0) && ticks <= (g ? 22 : 1), 1'b1)
    `CHK(sig_sel_q, c <= 4'h7 ? 8'h01 << c : dif ? 8'h01 << (2 * (c - 4'hA)) : 8'h00)
    `CHK(ref_sel_q, dif ? 8'h02 << (2 * (c - 4'hA)) : 8'h00)
    `CHK({ref_gnd_q, trim_sel_q, sel_reserved_q}, {c <= 4'h7, c == 4'hF, c inside {4'h8, 4'h9, 4'hE}})
    `CHK(amp_en_q, g)
    if (poke) begin
      converter_control_word = 16'h7800;
      start = 1'b1;
      step(1);
      start = 1'b0;
      ce = 1'b0;
      step(20);
      `CHK(busy_q, 1'b1)
      ce = 1'b1;
    end
    for (w = 0; w < 2000 && done_q !== 1'b1; w++) step(1);
    `CHK(ticks >= (g ? 52 : 31) && ticks <= (g ? 54 : 33), 1'b1)
    // unity time at the nominal clock, to within one half-period.
    ns = (ticks * sarseq_pkg::CONV_CLK_NS / 2 - sarseq_pkg::UNITY_CONV_NS) / (sarseq_pkg::CONV_CLK_NS / 2);
    if (!g) `CHK(ns inside {-1, 0, 1}, 1'b1)
    `CHK(result_q, exp_res(c, g))
    `CHK(busy_q, 1'b0)
  endtask : run_conv
  // reset mid-conversion, then a clean conversion to show recovery.
  task automatic mid_reset();
    run_conv(4'h1, 1'b0, 1'b0);
    converter_control_word = 16'h0000;
    start = 1'b1;
    step(1);
    start = 1'b0;
    step(40);
    rst = 1'b1;
    step(1);
    rst = 1'b0;
    `CHK({busy_q, done_q, sar_active_q, cap_track_q}, 4'h0)
    run_conv(4'h5, 1'b0, 1'b0);
  endtask : mid_reset
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    #(20000 * 20);
    n_fail++;
    wrap_up();
  end
  initial begin
    step(6);
    rst = 1'b0;
    `CHK({busy_q, done_q, sig_sel_q, result_q}, 20'h0)
    for (int c = 0; c < 16; c++) run_conv(4'(c), 1'b0, 1'b0);
    run_conv(4'hF, 1'b1, 1'b0);
    run_conv(4'h3, 1'b1, 1'b0);
    run_conv(4'hA, 1'b1, 1'b1);
    run_conv(4'h2, 1'b0, 1'b1);
    mid_reset();
    wrap_up();
  end
endmodule : sarseq_top_tb
